/* src/pvc_pkg.sv */
`default_nettype none
package pvc_pkg;

	// ----------------------------------------
	// Operation codes and command block layout
	// ----------------------------------------
	localparam logic [7:0]  OP_V10     = 8'h2F;
	localparam logic [7:0]  OP_V12     = 8'hAF;
	localparam logic [7:0]  OP_V16     = 8'h8F;
	localparam logic [7:0]  OP_V32     = 8'h7F;
	localparam logic [7:0]  ADD_LEN32  = 8'h18;
	localparam logic [15:0] SA_V32     = 16'h000A;
	localparam int          CDB_BYTES  = 32;
	localparam int          CDB_TOP    = 8 * CDB_BYTES - 1;
	localparam int          B_OP       = 0;
	localparam int          B_FLAGS    = 1;
	localparam int          B_LBA      = 2;
	localparam int          B_LEN10    = 7;
	localparam int          B_LEN12    = 6;
	localparam int          B_LEN16    = 10;
	localparam int          B_ADDLEN   = 7;
	localparam int          B_SA       = 8;
	localparam int          B_FLAGS32  = 10;
	localparam int          B_LBA32    = 12;
	localparam int          B_REF32    = 20;
	localparam int          B_APP32    = 24;
	localparam int          B_MASK32   = 26;
	localparam int          B_LEN32    = 28;
	localparam int          VP_HI      = 7;
	localparam int          BC_HI      = 2;

	// ----------------------------------------
	// Field encodings
	// ----------------------------------------
	localparam logic [2:0]  VP_NONE    = 3'h0;
	localparam logic [2:0]  VP_ALL     = 3'h1;
	localparam logic [2:0]  VP_NOGUARD = 3'h2;
	localparam logic [2:0]  VP_SKIP    = 3'h3;
	localparam logic [2:0]  VP_GUARD   = 3'h4;
	localparam logic [1:0]  BC_MEDIA   = 2'h0;
	localparam logic [1:0]  BC_MULTI   = 2'h1;
	localparam logic [1:0]  BC_UNDEF   = 2'h2;
	localparam logic [1:0]  BC_SINGLE  = 2'h3;
	localparam logic [2:0]  PT_TYPE2   = 3'h1;

	// ----------------------------------------
	// Sense data
	// ----------------------------------------
	localparam logic [3:0]  SK_GOOD    = 4'h0;
	localparam logic [3:0]  SK_ILLEGAL = 4'h5;
	localparam logic [3:0]  SK_ABORTED = 4'hB;
	localparam logic [7:0]  ASC_NONE   = 8'h00;
	localparam logic [7:0]  ASC_INV_OP = 8'h20;
	localparam logic [7:0]  ASC_INV_FL = 8'h24;
	localparam logic [7:0]  ASC_PI     = 8'h10;
	localparam logic [7:0]  ASCQ_GUARD = 8'h01;
	localparam logic [7:0]  ASCQ_APP   = 8'h02;
	localparam logic [7:0]  ASCQ_REF   = 8'h03;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int          ADDR_W     = 8;
	localparam logic [7:0]  ADDR_CDB7  = 8'h1C;
	localparam logic [7:0]  ADDR_CTRL  = 8'h20;
	localparam logic [7:0]  ADDR_STAT  = 8'h24;
	localparam logic [7:0]  ADDR_DEC   = 8'h28;
	localparam logic [7:0]  ADDR_LBAL  = 8'h2C;
	localparam logic [7:0]  ADDR_LBAH  = 8'h30;
	localparam logic [7:0]  ADDR_LEN   = 8'h34;
	localparam logic [7:0]  ADDR_CNT   = 8'h38;
	localparam int          CTRL_START = 0;
	localparam int          CTRL_FMT   = 1;
	localparam int          CTRL_PT    = 2;
	localparam int          CTRL_ATO   = 5;
	localparam logic [5:0]  CTRL_RST   = 6'h00;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_DEC   = 2'h3;

	typedef enum logic [1:0] {ST_IDLE, ST_DECODE, ST_RUN, ST_DONE} pvc_state_t;

endpackage
`default_nettype wire

/* src/pvc_tag_cmp.sv */
`timescale 1ns/1ps
`default_nettype none
module pvc_tag_cmp #(
	parameter int W = 16
) (
	input  wire logic         en,
	input  wire logic [W-1:0] stored,
	input  wire logic [W-1:0] expected,
	input  wire logic [W-1:0] mask,
	output logic              miss
);
	if (W < 1) begin : g_bad_w
		$error("pvc_tag_cmp: W must be at least 1");
	end

	// Only bits whose mask bit is one take part
	assign miss = en && (|((stored ^ expected) & mask));
endmodule
`default_nettype wire

/* src/pvc_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module pvc_checker (
	input  wire logic                       clock,
	input  wire logic                       ce,
	input  wire logic                       rst_b,
	input  wire logic [pvc_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                       awvalid,
	output logic                            awready,
	input  wire logic [31:0]                wdata,
	input  wire logic [3:0]                 wstrb,
	input  wire logic                       wvalid,
	output logic                            wready,
	output logic [1:0]                      bresp,
	output logic                            bvalid,
	input  wire logic                       bready,
	input  wire logic [pvc_pkg::ADDR_W-1:0] araddr,
	input  wire logic                       arvalid,
	output logic                            arready,
	output logic [31:0]                     rdata,
	output logic [1:0]                      rresp,
	output logic                            rvalid,
	input  wire logic                       rready,
	output logic                            mediaStart,
	output logic [63:0]                     mediaLba,
	output logic [31:0]                     mediaLen,
	output logic                            mediaCompare,
	output logic                            mediaHostPi,
	output logic                            mediaPiCheck,
	output logic [31:0]                     dataOutBlocks,
	output logic                            busy,
	input  wire logic                       blkValid,
	input  wire logic                       blkGuardOk,
	input  wire logic [15:0]                blkGuard,
	input  wire logic [15:0]                blkAppTag,
	input  wire logic [31:0]                blkRefTag,
	input  wire logic [15:0]                hostGuard,
	input  wire logic [15:0]                hostAppTag,
	input  wire logic [31:0]                hostRefTag
);
	import pvc_pkg::*;

	pvc_state_t          stQ;
	logic [CDB_TOP:0]    cdbQ;
	logic [5:0]          ctrlQ;
	logic                awTakenQ, wTakenQ, bvalidQ, rvalidQ;
	logic [ADDR_W-1:0]   awAddrQ;
	logic [31:0]         wDataQ, rdataQ, rdD;
	logic [3:0]          wStrbQ;
	logic [1:0]          brespQ, rrespQ;
	logic                doWrite, wMapped, startReq;
	logic [7:0]          opD, flagsD;
	logic [2:0]          vpD;
	logic [1:0]          bcD;
	logic                is10, is12, is16, is32, fmt, app_tag_owner_bit, type2;
	logic [63:0]         lbaD;
	logic [31:0]         lenD;
	logic [3:0]          errSk;
	logic [7:0]          errAsc;
	logic                guardEnD, refEnD, appEnD, hostSrcD;
	logic [31:0]         dataOutD;
	logic                guardEnQ, refEnQ, appEnQ, hostSrcQ, is32Q, doneQ;
	logic [1:0]          bcQ;
	logic [31:0]         refQ, cntQ;
	logic [15:0]         appQ, maskQ;
	logic [3:0]          skQ;
	logic [7:0]          ascQ, ascqQ;
	logic                gMiss, aMiss, rMiss, guardFail, anyFail;

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	assign awready = !awTakenQ && !bvalidQ;
	assign wready  = !wTakenQ && !bvalidQ;
	assign bvalid  = bvalidQ;
	assign bresp   = brespQ;
	assign arready = !rvalidQ;
	assign rvalid  = rvalidQ;
	assign rdata   = rdataQ;
	assign rresp   = rrespQ;
	assign doWrite = awTakenQ && wTakenQ && !bvalidQ;
	assign wMapped = awAddrQ <= ADDR_CTRL;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			awTakenQ <= 1'b0;
			wTakenQ  <= 1'b0;
			bvalidQ  <= 1'b0;
			awAddrQ  <= '0;
			wDataQ   <= 32'h0;
			wStrbQ   <= 4'h0;
			brespQ   <= RESP_OKAY;
		end else if (ce) begin
			if (awvalid && awready) begin
				awTakenQ <= 1'b1;
				awAddrQ  <= awaddr;
			end
			if (wvalid && wready) begin
				wTakenQ <= 1'b1;
				wDataQ  <= wdata;
				wStrbQ  <= wstrb;
			end
			if (doWrite) begin
				awTakenQ <= 1'b0;
				wTakenQ  <= 1'b0;
				bvalidQ  <= 1'b1;
				brespQ   <= wMapped ? RESP_OKAY : RESP_DEC;
			end else if (bvalidQ && bready) begin
				bvalidQ <= 1'b0;
			end
		end
	end

	always_comb begin
		rdD = 32'h0;
		if (araddr <= ADDR_CDB7) begin
			for (int k = 0; k < 4; k++) begin
				rdD[8*k +: 8] = cdbQ[CDB_TOP - 8 * (4 * int'(araddr[4:2]) + k) -: 8];
			end
		end else if (araddr == ADDR_CTRL) begin
			rdD = {26'h0, ctrlQ[5:1], 1'b0};
		end else if (araddr == ADDR_STAT) begin
			rdD = {8'h00, ascqQ, ascQ, skQ, 1'b0, skQ != SK_GOOD, doneQ, busy};
		end else if (araddr == ADDR_DEC) begin
			rdD = {25'h0, bcQ, hostSrcQ, refEnQ, appEnQ, guardEnQ, is32Q};
		end else if (araddr == ADDR_LBAL) begin
			rdD = mediaLba[31:0];
		end else if (araddr == ADDR_LBAH) begin
			rdD = mediaLba[63:32];
		end else if (araddr == ADDR_LEN) begin
			rdD = mediaLen;
		end else if (araddr == ADDR_CNT) begin
			rdD = cntQ;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			rvalidQ <= 1'b0;
			rdataQ  <= 32'h0;
			rrespQ  <= RESP_OKAY;
		end else if (ce) begin
			if (arvalid && arready) begin
				rvalidQ <= 1'b1;
				rdataQ  <= rdD;
				rrespQ  <= (araddr <= ADDR_CNT) ? RESP_OKAY : RESP_DEC;
			end else if (rvalidQ && rready) begin
				rvalidQ <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Command block and control storage
	// ----------------------------------------
	// Writes while a command runs are dropped so the decode stays stable
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			cdbQ  <= '0;
			ctrlQ <= CTRL_RST;
		end else if (ce && doWrite && stQ == ST_IDLE) begin
			if (awAddrQ <= ADDR_CDB7) begin
				for (int n = 0; n < CDB_BYTES; n++) begin
					if (n / 4 == int'(awAddrQ[4:2]) && wStrbQ[n % 4]) begin
						cdbQ[CDB_TOP - 8 * n -: 8] <= wDataQ[8 * (n % 4) +: 8];
					end
				end
			end else if (awAddrQ == ADDR_CTRL && wStrbQ[0]) begin
				ctrlQ <= {wDataQ[5:1], 1'b0};
			end
		end
	end

	assign startReq = doWrite && stQ == ST_IDLE && awAddrQ == ADDR_CTRL && wStrbQ[0]
		&& wDataQ[CTRL_START];
	assign fmt      = ctrlQ[CTRL_FMT];
	assign app_tag_owner_bit      = ctrlQ[CTRL_ATO];
	assign type2    = fmt && ctrlQ[CTRL_PT +: 3] == PT_TYPE2;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	assign opD    = cdbQ[CDB_TOP - 8 * B_OP -: 8];
	assign is10   = opD == OP_V10;
	assign is12   = opD == OP_V12;
	assign is16   = opD == OP_V16;
	assign is32   = opD == OP_V32;
	assign flagsD = is32 ? cdbQ[CDB_TOP - 8 * B_FLAGS32 -: 8] : cdbQ[CDB_TOP - 8 * B_FLAGS -: 8];
	assign vpD    = flagsD[VP_HI -: 3];
	assign bcD    = flagsD[BC_HI -: 2];

	always_comb begin
		lbaD = 64'h0;
		lenD = 32'h0;
		if (is32) begin
			lbaD = cdbQ[CDB_TOP - 8 * B_LBA32 -: 64];
			lenD = cdbQ[CDB_TOP - 8 * B_LEN32 -: 32];
		end else if (is16) begin
			lbaD = cdbQ[CDB_TOP - 8 * B_LBA -: 64];
			lenD = cdbQ[CDB_TOP - 8 * B_LEN16 -: 32];
		end else if (is12) begin
			lbaD = {32'h0, cdbQ[CDB_TOP - 8 * B_LBA -: 32]};
			lenD = cdbQ[CDB_TOP - 8 * B_LEN12 -: 32];
		end else if (is10) begin
			lbaD = {32'h0, cdbQ[CDB_TOP - 8 * B_LBA -: 32]};
			lenD = {16'h0, cdbQ[CDB_TOP - 8 * B_LEN10 -: 16]};
		end
	end

	// Validity of every field is settled before any media access
	always_comb begin
		errSk  = SK_GOOD;
		errAsc = ASC_NONE;
		if (!(is10 || is12 || is16 || is32) || (is32 && !type2)) begin
			errSk  = SK_ILLEGAL;
			errAsc = ASC_INV_OP;
		end else if ((is32 && (cdbQ[CDB_TOP - 8 * B_ADDLEN -: 8] != ADD_LEN32
			|| cdbQ[CDB_TOP - 8 * B_SA -: 16] != SA_V32))
			|| bcD == BC_UNDEF
			|| vpD > VP_GUARD
			|| (!fmt && vpD != VP_NONE)) begin
			errSk  = SK_ILLEGAL;
			errAsc = ASC_INV_FL;
		end
	end

	// Without protection information nothing but user data is checked
	assign guardEnD = fmt && (vpD == VP_NONE || vpD == VP_ALL || vpD == VP_GUARD);
	assign refEnD   = fmt && (vpD == VP_NONE || vpD == VP_ALL || vpD == VP_NOGUARD);
	assign appEnD   = refEnD && is32 && app_tag_owner_bit;
	assign hostSrcD = bcD != BC_MEDIA && vpD != VP_NONE;

	always_comb begin
		dataOutD = 32'h0;
		if (bcD == BC_MULTI) begin
			dataOutD = lenD;
		end else if (bcD == BC_SINGLE) begin
			dataOutD = {31'h0, lenD != 32'h0};
		end
	end

	// ----------------------------------------
	// Command state
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			stQ <= ST_IDLE;
		end else if (ce) begin
			case (stQ)
				ST_IDLE: begin
					if (startReq) begin
						stQ <= ST_DECODE;
					end
				end
				ST_DECODE: begin
					if (errSk != SK_GOOD || lenD == 32'h0) begin
						stQ <= ST_DONE;
					end else begin
						stQ <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (blkValid && (anyFail || cntQ + 32'h1 == mediaLen)) begin
						stQ <= ST_DONE;
					end
				end
				default: begin
					stQ <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			guardEnQ      <= 1'b0;
			refEnQ        <= 1'b0;
			appEnQ        <= 1'b0;
			hostSrcQ      <= 1'b0;
			is32Q         <= 1'b0;
			bcQ           <= BC_MEDIA;
			refQ          <= 32'h0;
			appQ          <= 16'h0;
			maskQ         <= 16'h0;
			mediaLba      <= 64'h0;
			mediaLen      <= 32'h0;
			dataOutBlocks <= 32'h0;
		end else if (ce && stQ == ST_DECODE) begin
			guardEnQ      <= guardEnD;
			refEnQ        <= refEnD;
			appEnQ        <= appEnD;
			hostSrcQ      <= hostSrcD;
			is32Q         <= is32;
			bcQ           <= bcD;
			refQ          <= is32 ? cdbQ[CDB_TOP - 8 * B_REF32 -: 32] : lbaD[31:0];
			appQ          <= app_tag_owner_bit ? cdbQ[CDB_TOP - 8 * B_APP32 -: 16] : 16'h0;
			maskQ         <= app_tag_owner_bit ? cdbQ[CDB_TOP - 8 * B_MASK32 -: 16] : 16'h0;
			mediaLba      <= lbaD;
			mediaLen      <= lenD;
			dataOutBlocks <= (errSk == SK_GOOD) ? dataOutD : 32'h0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			mediaStart <= 1'b0;
		end else if (ce) begin
			mediaStart <= stQ == ST_DECODE && errSk == SK_GOOD && lenD != 32'h0;
		end
	end

	assign busy         = stQ != ST_IDLE && stQ != ST_DONE;
	assign mediaCompare = bcQ != BC_MEDIA;
	assign mediaHostPi  = hostSrcQ;
	assign mediaPiCheck = guardEnQ || refEnQ || appEnQ;

	// ----------------------------------------
	// Protection field checks
	// ----------------------------------------
	pvc_tag_cmp #(.W(16)) uGuard (
		.en       (guardEnQ && hostSrcQ),
		.stored   (blkGuard),
		.expected (hostGuard),
		.mask     (16'hFFFF),
		.miss     (gMiss)
	);

	pvc_tag_cmp #(.W(16)) uApp (
		.en       (appEnQ),
		.stored   (blkAppTag),
		.expected (hostSrcQ ? hostAppTag : appQ),
		.mask     (maskQ),
		.miss     (aMiss)
	);

	// Without a host source the reference tag advances by one per block from the initial value
	pvc_tag_cmp #(.W(32)) uRef (
		.en       (refEnQ),
		.stored   (blkRefTag),
		.expected (hostSrcQ ? hostRefTag : refQ + cntQ),
		.mask     (32'hFFFF_FFFF),
		.miss     (rMiss)
	);

	assign guardFail = gMiss || (guardEnQ && !hostSrcQ && !blkGuardOk);
	assign anyFail   = guardFail || aMiss || rMiss;

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			cntQ <= 32'h0;
		end else if (ce) begin
			if (stQ == ST_DECODE) begin
				cntQ <= 32'h0;
			end else if (stQ == ST_RUN && blkValid && !anyFail) begin
				cntQ <= cntQ + 32'h1;
			end
		end
	end

	// ----------------------------------------
	// Completion and sense
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			skQ   <= SK_GOOD;
			ascQ  <= ASC_NONE;
			ascqQ <= ASC_NONE;
		end else if (ce) begin
			if (stQ == ST_DECODE) begin
				skQ   <= errSk;
				ascQ  <= errAsc;
				ascqQ <= ASC_NONE;
			end else if (stQ == ST_RUN && blkValid && anyFail) begin
				skQ   <= SK_ABORTED;
				ascQ  <= ASC_PI;
				ascqQ <= guardFail ? ASCQ_GUARD : (aMiss ? ASCQ_APP : ASCQ_REF);
			end
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_b) begin
			doneQ <= 1'b0;
		end else if (ce) begin
			if (stQ == ST_DONE) begin
				doneQ <= 1'b1;
			end else if (startReq) begin
				doneQ <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	property p_vp_reserved;
		ce && stQ == ST_DECODE && vpD > VP_GUARD |=> stQ == ST_DONE && skQ == SK_ILLEGAL;
	endproperty
	a_vp_reserved: assert property (p_vp_reserved) else $error("reserved field accepted");

	property p_no_pi;
		ce && stQ == ST_DECODE && !fmt && vpD != VP_NONE |=> skQ == SK_ILLEGAL && !mediaStart;
	endproperty
	a_no_pi: assert property (p_no_pi) else $error("field set without protection");

	property p_type2;
		ce && stQ == ST_DECODE && is32 && !type2 |=> skQ == SK_ILLEGAL && ascQ == ASC_INV_OP;
	endproperty
	a_type2: assert property (p_type2) else $error("32-byte form ran without type 2");

	property p_zero_len;
		ce && stQ == ST_DECODE && errSk == SK_GOOD && lenD == 32'h0
			|=> stQ == ST_DONE && skQ == SK_GOOD ##1 !mediaStart;
	endproperty
	a_zero_len: assert property (p_zero_len) else $error("zero length not clean");

	property p_start_ok;
		mediaStart |-> skQ == SK_GOOD && stQ == ST_RUN && $past(stQ) == ST_DECODE;
	endproperty
	a_start_ok: assert property (p_start_ok) else $error("media started on bad command");

	property p_app_32;
		ce && stQ == ST_DECODE && !(is32 && app_tag_owner_bit) |=> !appEnQ;
	endproperty
	a_app_32: assert property (p_app_32) else $error("application tag check off 32-byte");

	property p_guard_fail;
		ce && stQ == ST_RUN && blkValid && guardFail
			|=> stQ == ST_DONE && skQ == SK_ABORTED && ascqQ == ASCQ_GUARD;
	endproperty
	a_guard_fail: assert property (p_guard_fail) else $error("guard failure not reported");

	property p_skip_all;
		ce && stQ == ST_DECODE && fmt && vpD == VP_SKIP |=> !guardEnQ && !refEnQ && !appEnQ;
	endproperty
	a_skip_all: assert property (p_skip_all) else $error("checks enabled for skip value");

	property p_host_src;
		ce && stQ == ST_DECODE |=> hostSrcQ == (bcQ != BC_MEDIA && $past(vpD) != VP_NONE);
	endproperty
	a_host_src: assert property (p_host_src) else $error("wrong comparison source");

	c_good: cover property (stQ == ST_RUN ##[1:50] stQ == ST_DONE && skQ == SK_GOOD);
	c_abort: cover property (stQ == ST_RUN ##[1:50] skQ == SK_ABORTED);
	c_illegal: cover property (stQ == ST_DECODE ##1 skQ == SK_ILLEGAL);
endmodule
`default_nettype wire

/* test/pvc_media_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pvc_media_model (
	input  wire logic        clock,
	input  wire logic        rst_b,
	input  wire logic        mediaStart,
	input  wire logic [31:0] mediaLen,
	input  wire logic        busy,
	input  wire logic [31:0] refBase,
	input  wire logic [15:0] appVal,
	output logic             blkValid,
	output logic             blkGuardOk,
	output logic [15:0]      blkGuard,
	output logic [15:0]      blkAppTag,
	output logic [31:0]      blkRefTag
);
	logic [31:0] left_q;
	logic [31:0] idx_q;
	// ----------------------------------------
	// One block every other cycle while running
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			left_q   <= 32'h0;
			idx_q    <= 32'h0;
			blkValid <= 1'b0;
		end else if (mediaStart) begin
			left_q   <= mediaLen;
			idx_q    <= 32'h0;
			blkValid <= 1'b0;
		end else if (!busy) begin
			// A cut run leaves no blocks pending
			left_q   <= 32'h0;
			blkValid <= 1'b0;
		end else if (blkValid) begin
			blkValid <= 1'b0;
			idx_q    <= idx_q + 32'h1;
		end else if (busy && left_q != 32'h0) begin
			blkValid <= 1'b1;
			left_q   <= left_q - 32'h1;
		end
	end
	// Fields outside a block show the inverse
	assign blkGuardOk = blkValid;
	assign blkGuard   = blkValid ? 16'h5A5A : 16'hA5A5;
	assign blkAppTag  = blkValid ? appVal : ~appVal;
	assign blkRefTag  = blkValid ? refBase + idx_q : ~(refBase + idx_q);
endmodule
`default_nettype wire

/* test/pvc_checker_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pvc_checker_tb;
	import pvc_pkg::*;
	logic clock, rst_b, awvalid, wvalid, arvalid, blkValid, blkGuardOk;
	logic mediaStart, mediaCompare, mediaHostPi, mediaPiCheck, busy;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, mediaLen, dataOutBlocks, blkRefTag, refBase, v;
	logic [1:0] bresp, rresp, r;
	logic [63:0] mediaLba;
	logic [15:0] blkGuard, blkAppTag, appVal, hostFlip;
	logic [7:0] cb [32];
	int miscompares, checks, starts, cyc;
	pvc_checker i_pvc_checker (.clock(clock), .ce(1'b1), .rst_b(rst_b), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(1'b1), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(1'b1), .mediaStart(mediaStart), .mediaLba(mediaLba), .mediaLen(mediaLen),
		.mediaCompare(mediaCompare), .mediaHostPi(mediaHostPi), .mediaPiCheck(mediaPiCheck),
		.dataOutBlocks(dataOutBlocks), .busy(busy), .blkValid(blkValid),
		.blkGuardOk(blkGuardOk), .blkGuard(blkGuard), .blkAppTag(blkAppTag),
		.blkRefTag(blkRefTag), .hostGuard(blkGuard ^ hostFlip), .hostAppTag(blkAppTag),
		.hostRefTag(blkRefTag));
	pvc_media_model i_pvc_media_model (.clock(clock), .rst_b(rst_b), .mediaStart(mediaStart),
		.mediaLen(mediaLen), .busy(busy), .refBase(refBase), .appVal(appVal),
		.blkValid(blkValid), .blkGuardOk(blkGuardOk), .blkGuard(blkGuard),
		.blkAppTag(blkAppTag), .blkRefTag(blkRefTag));
	// ----------------------------------------
	// Clock, watchdog, start counter
	// ----------------------------------------
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc++;
		if (mediaStart) starts++;
		if (cyc == 30000) begin
			miscompares++;
			test_done();
		end
	end
	// ----------------------------------------
	// Bus and command tasks
	// ----------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		do begin
			@(posedge clock);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
	endtask
	task rd(input logic [7:0] a);
		araddr  <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge clock);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		v = rdata;
		r = rresp;
	endtask
	function logic [31:0] st(logic [3:0] sk, logic [7:0] asc, logic [7:0] q);
		return {8'h00, q, asc, sk, 1'b0, sk != 4'h0, 2'b10};
	endfunction
	task put(input int at, input int n, input logic [63:0] d);
		for (int i = 0; i < n; i++) cb[at + i] = d[8 * (n - 1 - i) +: 8];
	endtask
	task cmd(input logic [5:0] ctl, input logic [31:0] eSt, input logic [6:0] eDec,
		input int eStarts);
		int s;
		s = starts;
		for (int w = 0; w < 8; w++) wr(8'(4 * w), {cb[4*w+3], cb[4*w+2], cb[4*w+1], cb[4*w]});
		wr(ADDR_CTRL, {26'h0, ctl | 6'h01});
		v = 32'h0;
		for (int i = 0; i < 200 && v[1] !== 1'b1; i++) rd(ADDR_STAT);
		chk(v, eSt);
		rd(ADDR_DEC);
		chk({25'h0, v[6:0]}, {25'h0, eDec});
		chk(starts - s, eStarts);
		chk({29'h0, mediaCompare, mediaHostPi, mediaPiCheck},
			{29'h0, eDec[6:5] != 2'h0, eDec[4], |eDec[3:1]});
	endtask
	task c16(input logic [2:0] vp, input logic [1:0] bc, input logic [31:0] len);
		cb = '{default: 8'h00};
		cb[0] = OP_V16;
		cb[1] = {vp, 2'b00, bc, 1'b0};
		put(2, 8, 64'h0000_0001_0000_0010);
		put(10, 4, len);
	endtask
	task c32(input logic [15:0] sa, input logic [15:0] app, input logic [15:0] mask);
		cb = '{default: 8'h00};
		cb[0] = OP_V32;
		cb[7] = ADD_LEN32;
		put(8, 2, sa);
		cb[10] = 8'h20;
		put(12, 8, 64'h0000_0002_0000_0040);
		put(20, 4, 32'h0000_0100);
		put(24, 2, app);
		put(26, 2, mask);
		put(28, 4, 32'h2);
	endtask
	task test_done();
		if (miscompares == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	logic [6:0] decT [5] = '{7'h0A, 7'h0A, 7'h08, 7'h00, 7'h02};
	initial begin
		{miscompares, checks, starts, cyc} = '0;
		{rst_b, awvalid, wvalid, arvalid, awaddr, araddr, wdata} = '0;
		refBase = 32'h11223344;
		appVal = 16'hABCD;
		hostFlip = 16'h0;
		repeat (8) @(posedge clock);
		rst_b <= 1'b1;
		rd(ADDR_CTRL);
		chk(v, 32'h0);
		rd(ADDR_STAT);
		chk(v, 32'h0);
		rd(8'h3C);
		chk(r, RESP_DEC);
		wr(ADDR_STAT, 32'h0);
		chk(r, RESP_DEC);
		cb = '{default: 8'h00};
		cb[0] = OP_V12;
		put(2, 4, 32'h11223344);
		put(6, 4, 32'h3);
		cmd(6'h00, st(0, 0, 0), 7'h00, 1);
		rd(ADDR_LBAL);
		chk(v, 32'h11223344);
		rd(ADDR_CNT);
		chk(v, 32'h3);
		chk(mediaLen, 32'h3);
		refBase = 32'h10;
		for (int p = 0; p < 5; p++) begin
			c16(3'(p), 2'h0, 32'h2);
			cmd(6'h06, st(0, 0, 0), decT[p], 1);
		end
		rd(ADDR_LBAH);
		chk(v, 32'h1);
		for (int p = 5; p < 8; p++) begin
			c16(3'(p), 2'h0, 32'h2);
			cmd(6'h06, st(SK_ILLEGAL, ASC_INV_FL, 0), 7'h00, 0);
		end
		c16(VP_ALL, 2'h0, 32'h2);
		cmd(6'h00, st(SK_ILLEGAL, ASC_INV_FL, 0), 7'h00, 0);
		c16(VP_ALL, BC_MULTI, 32'h2);
		cmd(6'h06, st(0, 0, 0), 7'h3A, 1);
		chk(dataOutBlocks, 32'h2);
		c16(VP_ALL, BC_SINGLE, 32'h2);
		cmd(6'h06, st(0, 0, 0), 7'h7A, 1);
		chk(dataOutBlocks, 32'h1);
		hostFlip <= 16'h0001;
		c16(VP_GUARD, BC_MULTI, 32'h2);
		cmd(6'h06, st(SK_ABORTED, ASC_PI, ASCQ_GUARD), 7'h32, 1);
		hostFlip <= 16'h0;
		c16(VP_NONE, BC_MULTI, 32'h2);
		cmd(6'h06, st(0, 0, 0), 7'h2A, 1);
		c16(VP_ALL, BC_UNDEF, 32'h2);
		cmd(6'h06, st(SK_ILLEGAL, ASC_INV_FL, 0), 7'h5A, 0);
		c16(VP_ALL, 2'h0, 32'h0);
		cmd(6'h06, st(0, 0, 0), 7'h0A, 0);
		refBase = 32'h100;
		c32(SA_V32, 16'hAB00, 16'hFF00);
		cmd(6'h02, st(SK_ILLEGAL, ASC_INV_OP, 0), 7'h0B, 0);
		cmd(6'h26, st(0, 0, 0), 7'h0F, 1);
		rd(ADDR_LBAL);
		chk(v, 32'h40);
		refBase = 32'h101;
		cmd(6'h26, st(SK_ABORTED, ASC_PI, ASCQ_REF), 7'h0F, 1);
		refBase = 32'h100;
		appVal = 16'hCC00;
		cmd(6'h26, st(SK_ABORTED, ASC_PI, ASCQ_APP), 7'h0F, 1);
		cmd(6'h06, st(0, 0, 0), 7'h0B, 1);
		c32(16'h000B, 16'h0, 16'h0);
		cmd(6'h26, st(SK_ILLEGAL, ASC_INV_FL, 0), 7'h0F, 0);
		test_done();
	end
endmodule
`default_nettype wire
